// [rtl/adc_conversion_sequencer.sv]
// Conversion sequencer for a 12-bit successive-approximation converter
//
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Converter powered only while power-enable bit is set; conversions need it.
// - Sampling phase lasts exactly 4 conversion-clock cycles.
// - Then 12 conversion cycles follow; whole conversion is 16 cycles.
// - Conversion runs autonomously in hardware; bus stays free meanwhile.
// - Busy flag high during conversion, low when it completes.
// - Result appears in high and low byte registers after busy falls.
// - Result placement across the byte pair follows the format bit.
// - Completion requests interrupt only when all three enables are set.
// - Completion request is an end-of-conversion signal, alternative to polling.
// - Divider codes 000 to 111 divide system clock by 1 to 128.
// - Internal source selected disconnects external path regardless of channel.
// - External source: four-bit channel field picks the routed pin.
// - Source 000,101-111 external; 001 bandgap, 010/011 amplifiers, 100 ground.
// - Reference code 01 uses internal supply; 00 and 1x external pin.
// - Result is 12-bit unsigned, full scale all ones.
// - Clearing power-enable switches the conversion circuitry off.
module adc_conversion_sequencer
   import adc_seq_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // Wishbone classic slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Analog core
   input  wire logic        cmp_above,       // Comparator: input at or above trial level
   output logic             conv_power,
   output logic             sample_hold,     // High while the input is being sampled
   output logic [11:0]      dac_code,        // Trial code for the comparator
   output logic             ext_path_enable,
   output logic [3:0]       ext_channel,
   output logic [3:0]       internal_source, // One-hot: bandgap, amp a, amp b, ground
   output logic             ref_use_supply,
   output logic             conv_busy,
   output logic             conv_irq_request
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  cmp_sync;     // [0] is the first stage
      logic        cmp_level;
      logic        power;
      logic        fmt;
      logic        start;
      logic [3:0]  chan;
      logic [2:0]  src;
      logic [1:0]  ref_sel;
      logic [2:0]  div_sel;
      logic        gie;
      logic        cie;
      logic        mfie;
      logic        done_flag;
      conv_state_t state;
      logic [6:0]  prescale;
      logic [3:0]  phase;
      logic [11:0] sar;
      logic [11:0] mask;
      logic [11:0] result;
      logic        ack;
      logic [31:0] rdata;
      logic        busy;
      logic        sample;
      logic        ext_en;
      logic [3:0]  int_sel;
      logic        ref_supply;
      logic        irq;
   } seq_state_t;

   seq_state_t state_q;
   seq_state_t next_state;

   logic [6:0]  div_limit;
   logic        tick;
   logic        req;
   logic        wr;
   logic [7:0]  reg0_view;
   logic [7:0]  reg1_view;
   logic [7:0]  irq_view;
   logic [7:0]  res_high;
   logic [7:0]  res_low;

   // ------------------------------------------------------------------
   // Conversion clock and register views
   // ------------------------------------------------------------------
   // divide by power of two
   assign div_limit = 7'((8'h01 << state_q.div_sel) - 8'h01);
   // One system cycle per conversion-clock period; no gated clock needed
   assign tick      = (state_q.prescale == div_limit);

   assign req = wb_cyc_i && wb_stb_i && !state_q.ack;
   assign wr  = req && wb_we_i && wb_sel_i[0];

   assign reg0_view = {state_q.start, state_q.busy, state_q.power, state_q.fmt, state_q.chan};
   assign reg1_view = {state_q.src, state_q.ref_sel, state_q.div_sel};
   assign irq_view  = {4'h0, state_q.done_flag, state_q.mfie, state_q.cie, state_q.gie};

   // result bytes readable after busy falls
   always_comb begin
      if (state_q.fmt) begin
         res_high = {4'h0, state_q.result[11:8]};
         res_low  = state_q.result[7:0];
      end else begin
         res_high = state_q.result[11:4];
         res_low  = {state_q.result[3:0], 4'h0};
      end
   end

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   // Bus access first, then the sequencer itself, then the start edges
   always_comb begin
      next_state = state_q;

      // Comparator crosses from the analog domain: three stages, agree to accept
      next_state.cmp_sync = {state_q.cmp_sync[1:0], cmp_above};
      if (state_q.cmp_sync[1] == state_q.cmp_sync[2]) begin
         next_state.cmp_level = state_q.cmp_sync[2];
      end

      // Bus answer: one cycle after the request, dropped the cycle after
      next_state.ack   = req;
      next_state.rdata = UNMAPPED_READ;
      if (req && !wb_we_i) begin
         if (wb_adr_i == OFS_CONV_CONTROL_REG0) begin
            next_state.rdata = {24'h0, reg0_view};
         end else if (wb_adr_i == OFS_CONV_CONTROL_REG1) begin
            next_state.rdata = {24'h0, reg1_view};
         end else if (wb_adr_i == OFS_RESULT_LOW_BYTE) begin
            next_state.rdata = {24'h0, res_low};
         end else if (wb_adr_i == OFS_RESULT_HIGH_BYTE) begin
            next_state.rdata = {24'h0, res_high};
         end else if (wb_adr_i == OFS_IRQ_CONTROL) begin
            next_state.rdata = {24'h0, irq_view};
         end else begin
            next_state.rdata = UNMAPPED_READ;
         end
      end

      // Register writes; busy and result are read-only
      if (wr) begin
         if (wb_adr_i == OFS_CONV_CONTROL_REG0) begin
            next_state.start = wb_dat_i[BIT_START];
            next_state.power = wb_dat_i[BIT_POWER_ENABLE];
            next_state.fmt   = wb_dat_i[BIT_RESULT_FORMAT];
            next_state.chan  = wb_dat_i[LSB_EXT_CHANNEL +: 4];
         end else if (wb_adr_i == OFS_CONV_CONTROL_REG1) begin
            next_state.src     = wb_dat_i[LSB_SOURCE_SEL +: 3];
            next_state.ref_sel = wb_dat_i[LSB_REFERENCE_SEL +: 2];
            next_state.div_sel = wb_dat_i[LSB_CLOCK_DIVIDER_SEL +: 3];
         end else if (wb_adr_i == OFS_IRQ_CONTROL) begin
            next_state.gie  = wb_dat_i[BIT_GLOBAL_IRQ_EN];
            next_state.cie  = wb_dat_i[BIT_CONV_IRQ_EN];
            next_state.mfie = wb_dat_i[BIT_MULTI_IRQ_EN];
            // Write one to clear; a completion in the same cycle wins below
            if (wb_dat_i[BIT_DONE_FLAG]) begin
               next_state.done_flag = 1'b0;
            end
         end
      end

      // Conversion clock prescaler, free running between start edges
      next_state.prescale = tick ? 7'h00 : 7'(state_q.prescale + 7'h01);

      // sequencer runs on its own, bus never waits on it
      case (state_q.state)
         ST_IDLE: begin
         end
         ST_ARMED: begin
         end
         ST_SAMPLE: begin
            if (tick) begin
               next_state.phase = 4'(state_q.phase + 4'h1);
               if (state_q.phase == SAMPLE_TICKS - 4'h1) begin
                  next_state.state = ST_CONVERT;
                  next_state.phase = 4'h0;
                  next_state.sar   = SAR_FIRST_TRIAL;
                  next_state.mask  = SAR_FIRST_TRIAL;
               end
            end
         end
         ST_CONVERT: begin
            // twelve decision ticks, one bit each
            if (tick) begin
               next_state.phase = 4'(state_q.phase + 4'h1);
               next_state.mask  = state_q.mask >> 1;
               next_state.sar   = (state_q.cmp_level ? state_q.sar : (state_q.sar & ~state_q.mask))
                                  | (state_q.mask >> 1);
               if (state_q.phase == CONVERT_TICKS - 4'h1) begin
                  // all comparisons high give all ones
                  next_state.result    = state_q.cmp_level ? state_q.sar : (state_q.sar & ~state_q.mask);
                  next_state.state     = ST_IDLE;
                  // completion flag marks end of conversion
                  next_state.done_flag = 1'b1;
               end
            end
         end
         default: begin
            next_state.state = ST_IDLE;
         end
      endcase

      // rising start edge resets the conversion logic
      if (!state_q.start && next_state.start) begin
         next_state.state = ST_ARMED;
      end
      if (state_q.start && !next_state.start && state_q.state == ST_ARMED && state_q.power) begin
         next_state.state    = ST_SAMPLE;
         next_state.phase    = 4'h0;
         next_state.prescale = 7'h00;
      end

      // clearing power aborts and switches off
      if (!next_state.power) begin
         next_state.state = ST_IDLE;
      end

      // busy from sampling start to completion
      next_state.busy   = (next_state.state == ST_SAMPLE) || (next_state.state == ST_CONVERT);
      next_state.sample = (next_state.state == ST_SAMPLE);

      // internal source cuts the external path
      next_state.int_sel = 4'h0;
      next_state.ext_en  = 1'b0;
      if (next_state.src == SRC_BANDGAP) begin
         next_state.int_sel = 4'h1;
      end else if (next_state.src == SRC_AMP_A) begin
         next_state.int_sel = 4'h2;
      end else if (next_state.src == SRC_AMP_B) begin
         next_state.int_sel = 4'h4;
      end else if (next_state.src == SRC_NEG_SUPPLY) begin
         next_state.int_sel = 4'h8;
      end else begin
         next_state.ext_en = next_state.power;
      end

      next_state.ref_supply = (next_state.ref_sel == REF_INTERNAL_SUPPLY);

      // request only with all three enables
      next_state.irq = next_state.done_flag && next_state.gie && next_state.cie && next_state.mfie;
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Reset to all zeros: idle, powered off, registers at their reset values
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= '0;
      end else begin
         state_q <= next_state;
      end
   end

   // ------------------------------------------------------------------
   // Outputs, each straight from the state register
   // ------------------------------------------------------------------
   assign wb_dat_o         = state_q.rdata;
   assign wb_ack_o         = state_q.ack;
   assign conv_power       = state_q.power;
   assign sample_hold      = state_q.sample;
   assign dac_code         = state_q.sar;
   assign ext_path_enable  = state_q.ext_en;
   assign ext_channel      = state_q.chan;
   assign internal_source  = state_q.int_sel;
   assign ref_use_supply   = state_q.ref_supply;
   assign conv_busy        = state_q.busy;
   assign conv_irq_request = state_q.irq;

endmodule : adc_conversion_sequencer

`default_nettype wire

// [rtl/adc_seq_pkg.sv]
// Constants, register layout and state codes of the conversion sequencer
package adc_seq_pkg;

   // ------------------------------------------------------------------
   // Register byte offsets (one 32-bit word each, data in bits 7:0)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CONV_CONTROL_REG0 = 8'h00;
   localparam logic [7:0] OFS_CONV_CONTROL_REG1 = 8'h04;
   localparam logic [7:0] OFS_RESULT_LOW_BYTE   = 8'h08;
   localparam logic [7:0] OFS_RESULT_HIGH_BYTE  = 8'h0C;
   localparam logic [7:0] OFS_IRQ_CONTROL       = 8'h10;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   // conv_control_reg0
   localparam int BIT_START             = 7;
   localparam int BIT_BUSY              = 6;
   localparam int BIT_POWER_ENABLE      = 5;
   localparam int BIT_RESULT_FORMAT     = 4;
   localparam int LSB_EXT_CHANNEL       = 0;
   // conv_control_reg1
   localparam int LSB_SOURCE_SEL        = 5;
   localparam int LSB_REFERENCE_SEL     = 3;
   localparam int LSB_CLOCK_DIVIDER_SEL = 0;
   // irq control
   localparam int BIT_GLOBAL_IRQ_EN     = 0;
   localparam int BIT_CONV_IRQ_EN       = 1;
   localparam int BIT_MULTI_IRQ_EN      = 2;
   localparam int BIT_DONE_FLAG         = 3;

   // ------------------------------------------------------------------
   // Encodings, counts and reset values
   // ------------------------------------------------------------------
   localparam logic [2:0]  SRC_BANDGAP       = 3'h1;
   localparam logic [2:0]  SRC_AMP_A         = 3'h2;
   localparam logic [2:0]  SRC_AMP_B         = 3'h3;
   localparam logic [2:0]  SRC_NEG_SUPPLY    = 3'h4;
   localparam logic [1:0]  REF_INTERNAL_SUPPLY = 2'h1;
   localparam logic [3:0]  SAMPLE_TICKS      = 4'h4;
   localparam logic [3:0]  CONVERT_TICKS     = 4'hC;
   localparam logic [11:0] SAR_FIRST_TRIAL   = 12'h800;
   localparam logic [7:0]  RESET_REG0        = 8'h00;
   localparam logic [7:0]  RESET_REG1        = 8'h00;
   localparam logic [31:0] UNMAPPED_READ     = 32'h0000_0000;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_ARMED   = 2'b01,
      ST_SAMPLE  = 2'b10,
      ST_CONVERT = 2'b11
   } conv_state_t;

endpackage : adc_seq_pkg

// [test/adc_seq_assertions.sv]
// Port-level checks on the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_seq_assertions (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   input wire logic        sample_hold,
   input wire logic        conv_busy,
   input wire logic        conv_power,
   input wire logic        ext_path_enable,
   input wire logic [3:0]  internal_source,
   input wire logic        conv_irq_request
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // ----------------------------------------
   // Steps of a bus access and of a conversion
   // ----------------------------------------
   sequence s_request;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_sampling;
      sample_hold [*4];
   endsequence
   sequence s_converting;
      conv_busy [*8];
   endsequence
   a_ack_next: assert property (s_request |=> wb_ack_o)
      else $error("request left unanswered");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_data_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_sample_len: assert property ($rose(sample_hold) |-> s_sampling)
      else $error("sampling too short");
   a_convert_follows: assert property ($fell(sample_hold) |-> s_converting)
      else $error("conversion phase cut short");
   a_busy_sampling: assert property ($rose(conv_busy) |-> sample_hold)
      else $error("run did not open with sampling");
   a_busy_powered: assert property (conv_busy |-> conv_power && !$rose(conv_power))
      else $error("busy without power");
   a_sample_busy: assert property (sample_hold |-> conv_busy)
      else $error("sampling outside busy");
   a_ext_isolated: assert property (ext_path_enable |-> internal_source == 4'h0)
      else $error("external path with internal source");
   a_source_onehot: assert property ($onehot0(internal_source))
      else $error("several internal sources");
   a_irq_at_end: assert property ($rose(conv_irq_request) |-> !conv_busy)
      else $error("irq while busy");
endmodule : adc_seq_assertions
bind adc_conversion_sequencer adc_seq_assertions chk_u (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i,
   .wb_ack_o, .wb_dat_o, .sample_hold, .conv_busy, .conv_power, .ext_path_enable, .internal_source,
   .conv_irq_request);
`default_nettype wire

// [test/analog_model.sv]
// Comparator and analog sources beyond the sequencer
`timescale 1ns/1ns
`default_nettype none
module analog_model #(
   parameter logic [11:0] LV_BG = 12'h000,
   parameter logic [11:0] LV_A  = 12'h000,
   parameter logic [11:0] LV_B  = 12'h000
) (
   input  wire logic        clk_sys,
   input  wire logic        conv_power,
   input  wire logic        ext_path_enable,
   input  wire logic [3:0]  internal_source,
   input  wire logic [11:0] dac_code,
   input  wire logic [11:0] ext_level,
   output logic             cmp_above
);
   logic [11:0] lvl;
   logic        noise = 1'b0;
   // one source reaches the comparator; supply rail reads zero
   always_comb begin
      lvl = 12'h000;
      if (ext_path_enable) lvl = ext_level;
      else if (internal_source[0]) lvl = LV_BG;
      else if (internal_source[1]) lvl = LV_A;
      else if (internal_source[2]) lvl = LV_B;
   end
   // Unpowered output wanders, so a stale level never looks valid
   always @(posedge clk_sys) noise <= ~noise;
   // comparator works only with power on
   assign cmp_above = conv_power ? (lvl >= dac_code) : noise;
endmodule : analog_model
`default_nettype wire

// [test/testbench.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module testbench;
   import adc_seq_pkg::*;
   localparam logic [11:0] LV_BG = 12'h4D2, LV_A = 12'h9E7, LV_B = 12'h1F0;
   typedef struct {logic [2:0] div, src; logic [1:0] rf; logic fmt; logic [3:0] ch; logic [11:0] lv;} row_t;
   row_t        rows [9] = '{'{3, 0, 0, 0, 0, 12'hFFF}, '{4, 5, 1, 1, 13, 12'h000}, '{5, 1, 2, 0, 3, 12'h5A5},
      '{6, 2, 3, 1, 7, 12'h000}, '{3, 3, 1, 0, 14, 12'h000}, '{7, 4, 0, 1, 1, 12'hABC},
      '{0, 6, 1, 0, 2, 12'h3C3}, '{1, 7, 0, 1, 9, 12'hFFF}, '{2, 0, 2, 0, 5, 12'h123}};
   row_t        rw;
   logic        clk_sys = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
   logic [11:0] ext_level = 12'h000, dac_code;
   logic [3:0]  ext_channel, internal_source;
   logic        wb_ack_o, cmp_above, conv_power, sample_hold, ext_path_enable, ref_use_supply;
   logic        conv_busy, conv_irq_request;
   int          n_mismatch = 0, compares = 0, run_len = 0, last_len = 0;
   logic        ack_s = 0;
   logic [31:0] dat_s = 32'h0;
   // Bus answer copied mid-cycle, so the edge that follows sees settled values, not a race
   always @(negedge clk_sys) begin
      ack_s = wb_ack_o;
      dat_s = wb_dat_o;
   end
   adc_conversion_sequencer dut_u (.clk_sys, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .cmp_above, .conv_power, .sample_hold, .dac_code, .ext_path_enable,
      .ext_channel, .internal_source, .ref_use_supply, .conv_busy, .conv_irq_request);
   analog_model #(.LV_BG(LV_BG), .LV_A(LV_A), .LV_B(LV_B)) model_u (.clk_sys, .conv_power, .ext_path_enable,
      .internal_source, .dac_code, .ext_level, .cmp_above);
   initial forever #5 clk_sys = ~clk_sys;
   // Length of the latest busy run, in system cycles
   always @(negedge clk_sys) begin
      if (conv_busy === 1'b1) run_len <= run_len + 1;
      else if (run_len != 0) begin
         last_len <= run_len;
         run_len <= 0;
      end
   end
   // ----------------------------------------
   // Checking, bus and conversion helpers
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   // One classic cycle; request held until the edge that sees ack
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clk_sys);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, 24'h0, d, s};
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack_s !== 1'b1 && n < 50);
      rdata = dat_s;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      if (n >= 50) chk(0, 1);
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      bus(0, a, 8'h00, 4'hF);
   endtask : rd
   task automatic go(input logic [7:0] r0);
      wr(OFS_CONV_CONTROL_REG0, r0);
      wr(OFS_CONV_CONTROL_REG0, r0 | 8'h80);
      wr(OFS_CONV_CONTROL_REG0, r0);
   endtask : go
   // Poll busy over the bus; the bus answering meanwhile shows the run is autonomous
   task automatic fin(input logic [2:0] div);
      int n;
      n = 0;
      rd(OFS_CONV_CONTROL_REG0);
      chk(rdata[BIT_BUSY], 1);
      do begin
         rd(OFS_CONV_CONTROL_REG0);
         n++;
      end while (rdata[BIT_BUSY] !== 1'b0 && n < 3000);
      chk(last_len >= (16 << div) && last_len <= (16 << div) + 1, 1);
   endtask : fin
   task automatic chkres(input logic fmt, input logic [11:0] v);
      rd(OFS_RESULT_HIGH_BYTE);
      chk(rdata, fmt ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
      rd(OFS_RESULT_LOW_BYTE);
      chk(rdata, fmt ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
   endtask : chkres
   function automatic logic [11:0] lv_of(input logic [2:0] s, input logic [11:0] e);
      case (s)
         3'h1: return LV_BG;
         3'h2: return LV_A;
         3'h3: return LV_B;
         3'h4: return 12'h000;
         default: return e;
      endcase
   endfunction : lv_of
   // Long runs are bounded well under the cycle budget
   initial begin
      #900000;
      n_mismatch++;
      test_done;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      rd(OFS_CONV_CONTROL_REG0);
      chk(rdata, {24'h0, RESET_REG0});
      rd(8'h20);
      chk(rdata, UNMAPPED_READ);
      bus(1, OFS_CONV_CONTROL_REG1, 8'hFF, 4'hE);
      rd(OFS_CONV_CONTROL_REG1);
      chk(rdata, {24'h0, RESET_REG1});
      go(8'h10);
      repeat (4) @(posedge clk_sys);
      chk(conv_busy, 0);
      $display("reset and map test done");
      foreach (rows[i]) begin
         rw = rows[i];
         ext_level <= rw.lv;
         // divider, source and reference set before start; pin treated as analog
         wr(OFS_CONV_CONTROL_REG1, {rw.src, rw.rf, rw.div});
         go({3'b001, rw.fmt, rw.ch});
         fin(rw.div);
         chk(ext_channel, rw.ch);
         chk(ref_use_supply, rw.rf == 2'h1);
         chk(ext_path_enable, rw.src == 0 || rw.src > 4);
         chk(internal_source, (rw.src inside {[1:4]}) ? 4'h1 << (rw.src - 1) : 4'h0);
         if (rw.div > 2) chkres(rw.fmt, lv_of(rw.src, rw.lv));
      end
      $display("row test done");
      ext_level <= 12'h7FF;
      wr(OFS_CONV_CONTROL_REG1, 8'h03);
      wr(OFS_IRQ_CONTROL, 8'h0F);
      repeat (2) @(posedge clk_sys);
      chk(conv_irq_request, 0);
      go(8'h30);
      fin(3);
      repeat (2) @(posedge clk_sys);
      chk(conv_irq_request, 1);
      wr(OFS_IRQ_CONTROL, 8'h0F);
      repeat (2) @(posedge clk_sys);
      chk(conv_irq_request, 0);
      wr(OFS_IRQ_CONTROL, 8'h03);
      go(8'h30);
      fin(3);
      repeat (2) @(posedge clk_sys);
      chk(conv_irq_request, 0);
      $display("irq test done");
      go(8'h30);
      repeat (60) @(posedge clk_sys);
      wr(OFS_CONV_CONTROL_REG0, 8'hB0);
      @(posedge clk_sys);
      chk(conv_busy, 0);
      wr(OFS_CONV_CONTROL_REG0, 8'h30);
      fin(3);
      ext_level <= 12'h000;
      wr(OFS_CONV_CONTROL_REG1, 8'h07);
      go(8'h30);
      repeat (1000) @(posedge clk_sys);
      wr(OFS_CONV_CONTROL_REG0, 8'h10);
      repeat (2) @(posedge clk_sys);
      chk({conv_busy, conv_power}, 0);
      chkres(1, 12'h7FF);
      $display("restart and power-off test done");
      test_done;
   end
endmodule : testbench
`default_nettype wire
